//--- logic/hswh_pkg.sv
// package for the host sleep/wake handshake block
// assumes a 25 MHz module clock; link (spi) clock is a separate domain
package hswh_pkg;
    // clock rate and timing
    localparam int unsigned MCLK_HZ        = 25_000_000;
    localparam int unsigned DTIM_AWAKE_MS  = 30;
    localparam int unsigned DTIM_AWAKE_CYC = (MCLK_HZ / 1000) * DTIM_AWAKE_MS;
    // default wake time in ms and a default dtim period in ms (plain values)
    localparam int unsigned WAKE_TIME_MS   = 100;
    localparam int unsigned DTIM_PERIOD_MS = 100;
    localparam int unsigned CYC_PER_MS     = MCLK_HZ / 1000;
    // sleep mode encodings
    localparam logic [1:0] SMODE_NONE   = 2'h0;
    localparam logic [1:0] SMODE_PIN    = 2'h1;
    localparam logic [1:0] SMODE_CYCLIC = 2'h2;
    // sleep option encodings
    localparam logic       SOPT_DEEP    = 1'h0;
    localparam logic       SOPT_ASSOC   = 1'h1;
    // indicator pin config value selecting the awake indicator
    localparam logic [2:0] IND_CFG_AWAKE = 3'h1;
    // flow control pin config value selecting cts
    localparam logic [2:0] FLOW_CFG_CTS  = 3'h1;
    // sleep request pin config value selecting the sleep request
    localparam logic [2:0] SRQ_CFG_SLEEP = 3'h1;
    // reset values of outputs
    localparam logic       CTS_N_RST     = 1'h1;
    localparam logic       ATTN_N_RST    = 1'h1;

    typedef enum logic [1:0] {HSWH_ASLEEP, HSWH_AWAKE, HSWH_DRAIN} hswh_state_e;

    // configuration carried together
    typedef struct packed {
        logic [1:0] sleep_mode_select;
        logic       sleep_option;
        logic       spi_host;
        logic [2:0] indicator_pin_config;
        logic [2:0] flow_ctrl_pin_config;
        logic [2:0] sleep_req_pin_config;
    } hswh_cfg_s;

    // status shown to the rest of the module
    typedef struct packed {
        logic awake;
        logic tx_release;
        logic deliver_ok;
        logic associated;
    } hswh_stat_s;
endpackage

//--- logic/hswh_top.sv
// host sleep/wake handshake: sleep modes, awake/cts/attention pins
// assumes the radio core supplies dtim ticks, data events and assoc status on mclk
`timescale 1ns/10ps
module hswh_top
    import hswh_pkg::*;
#(
    parameter int unsigned WAKE_CYC  = WAKE_TIME_MS * CYC_PER_MS,
    parameter int unsigned SLEEP_CYC = DTIM_PERIOD_MS * CYC_PER_MS
) (
    // clock and reset
    input  wire logic             MCLK,
    input  wire logic             RST_N,
    // spi link clock
    input  wire logic             SPI_CLK,
    // configuration
    input  wire hswh_pkg::hswh_cfg_s CFG,
    // host pins (asynchronous)
    input  wire logic             SLEEP_REQUEST,
    input  wire logic             SPI_SSEL_N,
    // radio core events on mclk
    input  wire logic             INIT_DONE,
    input  wire logic             DTIM_TICK,
    input  wire logic             RX_DATA_PEND,
    input  wire logic             ACTIVITY,
    input  wire logic             ASSOC_DONE,
    // pin outputs
    output logic                  AWAKE_INDICATOR,
    output logic                  CTS_N,
    output logic                  ATTENTION_OUT_N,
    output logic                  STATUS_MSG,
    // status to the core
    output hswh_pkg::hswh_stat_s  STAT
);
    import hswh_pkg::*;

    // ==========================================================
    // elaboration checks
    // the dtim window is counted inside the wake time, so it must fit
    if (WAKE_CYC < DTIM_AWAKE_CYC || SLEEP_CYC < 1) begin : g_bad_cfg
        $error("wake time shorter than dtim window");
    end

    // ==========================================================
    // synchronisers
    logic [1:0] srq_s_r, ssel_s_r, drain_s_r;
    logic       srq, ssel_n, spi_drain;
    // crossing levels, declared here since both domains read them
    logic       spi_busy_r;
    logic       pend_r;
    // two flops per async input, only the second is read
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            srq_s_r   <= 2'h0;
            ssel_s_r  <= 2'h3;
            drain_s_r <= 2'h0;
        end else begin
            srq_s_r   <= {srq_s_r[0], SLEEP_REQUEST};
            ssel_s_r  <= {ssel_s_r[0], SPI_SSEL_N};
            drain_s_r <= {drain_s_r[0], spi_busy_r};
        end
    end
    assign srq       = srq_s_r[1];
    assign ssel_n    = ssel_s_r[1];
    assign spi_drain = drain_s_r[1];

    // ==========================================================
    // spi domain: data still being clocked out
    logic [1:0] pend_s_r;
    // limitation: busy only updates while the link clock runs, so a
    // frame cut with data pending keeps the drain state until it resumes
    // pending level crosses into link domain; cleared when clock stops only via reset
    always_ff @(posedge SPI_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_s_r   <= 2'h0;
            spi_busy_r <= 1'h0;
        end else begin
            pend_s_r   <= {pend_s_r[0], pend_r};
            spi_busy_r <= pend_s_r[1];
        end
    end

    // ==========================================================
    // mode decode
    logic pin_mode, cyc_mode, assoc_opt, req_sleep, uart;
    assign uart      = !CFG.spi_host;
    assign pin_mode  = CFG.sleep_mode_select == SMODE_PIN;
    assign cyc_mode  = CFG.sleep_mode_select == SMODE_CYCLIC;
    assign assoc_opt = CFG.sleep_option == SOPT_ASSOC;
    // high requests sleep; select low wakes
    assign req_sleep = uart ? srq : ssel_n;

    // ==========================================================
    // state and timers
    hswh_state_e state_r;
    logic [31:0] wake_cnt_r, sleep_cnt_r;
    logic        win_r, held_r, msg_sent_r, attn_now;
    logic        wake_exp, sleep_exp, allow_pin;
    assign wake_exp  = wake_cnt_r == 32'h0;
    assign sleep_exp = sleep_cnt_r == 32'h0;
    // pin sleep on a uart host needs the request pin function; a spi host does not
    assign allow_pin = pin_mode && (!uart || CFG.sleep_req_pin_config == SRQ_CFG_SLEEP);

    // pending received data, held until delivered
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_r <= 1'h0;
        end else if (RX_DATA_PEND) begin
            pend_r <= 1'h1;
        end else if (STAT.deliver_ok) begin
            pend_r <= 1'h0;
        end
    end

    // main sleep/wake sequencer
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r     <= HSWH_AWAKE;
            wake_cnt_r  <= 32'h0;
            sleep_cnt_r <= 32'h0;
            win_r       <= 1'h0;
        end else begin
            if (!wake_exp) wake_cnt_r <= wake_cnt_r - 32'h1;
            if (!sleep_exp) sleep_cnt_r <= sleep_cnt_r - 32'h1;
            case (state_r)
                HSWH_AWAKE: begin
                    if (allow_pin && req_sleep && !pend_r) begin
                        state_r <= HSWH_DRAIN;
                    end else if (cyc_mode && wake_exp && win_r) begin
                        state_r <= HSWH_DRAIN;
                    end else if (cyc_mode && !win_r) begin
                        // start one wake period, no restart
                        wake_cnt_r <= (assoc_opt && !ACTIVITY) ? DTIM_AWAKE_CYC : WAKE_CYC;
                        win_r      <= 1'h1;
                    end
                end
                HSWH_DRAIN: begin
                    if (!spi_drain) begin
                        state_r     <= HSWH_ASLEEP;
                        sleep_cnt_r <= SLEEP_CYC;
                    end
                end
                HSWH_ASLEEP: begin
                    win_r <= 1'h0;
                    if (pin_mode && (!req_sleep || !allow_pin)) begin
                        state_r <= HSWH_AWAKE;
                    end else if (cyc_mode && (assoc_opt ? DTIM_TICK : sleep_exp)) begin
                        state_r <= HSWH_AWAKE;
                    end else if (!pin_mode && !cyc_mode) begin
                        state_r <= HSWH_AWAKE;
                    end
                end
                default: state_r <= HSWH_AWAKE;
            endcase
        end
    end

    // held transmit data awaiting dtim
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            held_r <= 1'h0;
        end else if (ACTIVITY && state_r == HSWH_AWAKE && assoc_opt) begin
            // queue until next dtim
            // set wins over the dtim clear: new data waits for the next one
            held_r <= 1'h1;
        end else if (DTIM_TICK) begin
            held_r <= 1'h0;
        end
    end

    // ==========================================================
    // attention request and one status message per initialisation
    // attention on a spi host while awake or with data pending
    assign attn_now = CFG.spi_host && INIT_DONE && (pend_r || !asleep);
    // message flag drops with init so a re-init sends a new message
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            msg_sent_r <= 1'h0;
        end else begin
            msg_sent_r <= INIT_DONE && (msg_sent_r || attn_now);
        end
    end

    // ==========================================================
    // pin outputs, all registered
    logic asleep;
    // drain counts as asleep: the host is already told to stop
    assign asleep = state_r != HSWH_AWAKE;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            AWAKE_INDICATOR <= 1'h0;
            CTS_N           <= CTS_N_RST;
            ATTENTION_OUT_N <= ATTN_N_RST;
            STATUS_MSG      <= 1'h0;
            STAT            <= '0;
        end else begin
            AWAKE_INDICATOR <= uart && CFG.indicator_pin_config == IND_CFG_AWAKE && !asleep;
            CTS_N <= (CFG.flow_ctrl_pin_config == FLOW_CFG_CTS) ? asleep : 1'h0;
            // attention on a spi host after init while awake or with pending data
            ATTENTION_OUT_N <= !attn_now;
            // message pulses together with the first attention
            STATUS_MSG <= attn_now && !msg_sent_r;
            STAT.awake <= !asleep;
            // deliver only awake with request released
            STAT.deliver_ok <= !asleep && pend_r && !req_sleep;
            STAT.tx_release <= held_r && DTIM_TICK;
            STAT.associated <= assoc_opt ? ASSOC_DONE : (ASSOC_DONE && !asleep);
        end
    end

    // ==========================================================
    // assertions
    cts_sleep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (CFG.flow_ctrl_pin_config == FLOW_CFG_CTS && asleep) |=> CTS_N)
        else $error("cts low while asleep");
    cts_wake_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (CFG.flow_ctrl_pin_config == FLOW_CFG_CTS && !asleep) |=> !CTS_N)
        else $error("cts high while awake");
    ind_awake_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(AWAKE_INDICATOR) |-> $past(state_r) == HSWH_AWAKE)
        else $error("indicator up while asleep");
    no_pin_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (pin_mode && uart && CFG.sleep_req_pin_config != SRQ_CFG_SLEEP
         && state_r == HSWH_AWAKE) |=> state_r == HSWH_AWAKE)
        else $error("slept without request pin");
    deliver_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        STAT.deliver_ok |-> $past(!req_sleep))
        else $error("delivered under sleep request");
    asleep_ign_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        STAT.deliver_ok |-> $past(state_r) == HSWH_AWAKE)
        else $error("delivered while asleep");
    drain_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_r == HSWH_DRAIN && spi_drain) |=> state_r == HSWH_DRAIN)
        else $error("slept with data pending");
    ind_spi_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        CFG.spi_host |=> !AWAKE_INDICATOR)
        else $error("indicator driven on spi");

    // ==========================================================
    // sequences for the pin sleep entry and exit steps and the cyclic dtim wake
    sequence pin_sleep_req_s;
        state_r == HSWH_AWAKE && allow_pin && req_sleep && !pend_r;
    endsequence
    sequence pin_wake_req_s;
        state_r == HSWH_ASLEEP && pin_mode && !req_sleep;
    endsequence
    sequence dtim_wake_s;
        state_r == HSWH_ASLEEP && cyc_mode && assoc_opt && DTIM_TICK;
    endsequence

    pin_enter_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        pin_sleep_req_s |=> state_r == HSWH_DRAIN)
        else $error("sleep request not taken");
    pin_wake_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        pin_wake_req_s |=> state_r == HSWH_AWAKE)
        else $error("wake request not taken");
    dtim_wake_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        dtim_wake_s |=> state_r == HSWH_AWAKE)
        else $error("no wake on dtim");
    // no sleep mode selected keeps awake
    none_awake_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!pin_mode && !cyc_mode && state_r == HSWH_AWAKE) |=> state_r == HSWH_AWAKE)
        else $error("slept with no sleep mode");
    attn_init_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !INIT_DONE |=> ATTENTION_OUT_N)
        else $error("attention before init");
    // status message is a single pulse
    status_once_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        STATUS_MSG |=> !STATUS_MSG)
        else $error("status message repeated");
    attn_pend_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (CFG.spi_host && INIT_DONE && pend_r) |=> !ATTENTION_OUT_N)
        else $error("no attention with data pending");
    // queued data leaves only on dtim
    tx_queue_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        STAT.tx_release |-> $past(DTIM_TICK))
        else $error("queued data released off dtim");
    // wake timer only counts down while running
    wake_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (cyc_mode && state_r == HSWH_AWAKE && win_r && !wake_exp)
        |=> wake_cnt_r == $past(wake_cnt_r) - 32'h1)
        else $error("wake timer restarted");
endmodule

//--- test/hswh_host.sv
// local host model: sleep request pin, spi select and spi clock
// assumes the bench hands it MCLK; the spi clock stands low between frames
`timescale 1ns/10ps
module hswh_host (
    // clock
    input  wire logic MCLK,
    // host pins
    output logic      SLEEP_REQUEST,
    output logic      SPI_SSEL_N,
    output logic      SPI_CLK
);
    // pins idle: awake requested, device not selected
    initial begin
        SLEEP_REQUEST = 1'h0;
        SPI_SSEL_N    = 1'h1;
        SPI_CLK       = 1'h0;
    end
    task automatic set_sleep(input logic v);
        @(posedge MCLK);
        SLEEP_REQUEST <= v;
    endtask
    task automatic set_ssel(input logic v);
        @(posedge MCLK);
        SPI_SSEL_N <= v;
    endtask
    task automatic spi_frame(input int n);
        #7;
        for (int i = 0; i < n; i++) begin
            #16 SPI_CLK = 1'h1;
            #16 SPI_CLK = 1'h0;
        end
    endtask
endmodule

//--- test/hswh_top_tb.sv
// bench for the sleep/wake handshake, pin sleep on uart and spi hosts
// assumes the host model drives the pins; events come from this bench
`timescale 1ns/10ps
module hswh_top_tb;
    import hswh_pkg::*;
    logic       MCLK, RST_N, INIT_DONE, DTIM_TICK, RX_DATA_PEND, ACTIVITY;
    logic       awake_ind, cts_n, attn_n, assoc_done, status_msg;
    wire logic  sleep_req, ssel_n, spi_clk;
    hswh_cfg_s  cfg;
    hswh_stat_s stat;
    int         n_mismatch, check_count;

    // ========================================
    // instances
    // wake time kept at the dtim window so elaboration accepts it
    hswh_top #(.WAKE_CYC(750000), .SLEEP_CYC(200)) hswh_top_inst (
        .MCLK(MCLK), .RST_N(RST_N), .SPI_CLK(spi_clk), .CFG(cfg),
        .SLEEP_REQUEST(sleep_req), .SPI_SSEL_N(ssel_n), .INIT_DONE(INIT_DONE),
        .DTIM_TICK(DTIM_TICK), .RX_DATA_PEND(RX_DATA_PEND), .ACTIVITY(ACTIVITY),
        .ASSOC_DONE(assoc_done), .AWAKE_INDICATOR(awake_ind), .CTS_N(cts_n),
        .ATTENTION_OUT_N(attn_n), .STATUS_MSG(status_msg), .STAT(stat));
    hswh_host hswh_host_inst (.MCLK(MCLK), .SLEEP_REQUEST(sleep_req),
        .SPI_SSEL_N(ssel_n), .SPI_CLK(spi_clk));

    // ========================================
    // helpers
    // 25 MHz module clock
    initial begin
        MCLK = 1'h0;
        forever #20 MCLK = ~MCLK;
    end
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic probe(input int k);
        case (k)
            0: return awake_ind;
            1: return attn_n;
            2: return stat.deliver_ok;
            3: return stat.tx_release;
            default: return stat.awake;
        endcase
    endfunction
    // bounded wait, sampled mid-cycle so registered outputs have settled
    task automatic wait_lvl(input int k, input logic v, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge MCLK);
            if (probe(k) === v) break;
        end
        check(probe(k), v);
        if (i == n) test_done();
    endtask
    task automatic pulse(input int k);
        @(posedge MCLK);
        DTIM_TICK    <= (k == 0);
        RX_DATA_PEND <= (k == 1);
        ACTIVITY     <= (k == 2);
        @(posedge MCLK);
        {DTIM_TICK, RX_DATA_PEND, ACTIVITY} <= 3'h0;
    endtask
    task automatic set_cfg(input hswh_cfg_s c);
        @(posedge MCLK);
        cfg <= c;
    endtask

    // ========================================
    // scenarios
    // reset, pin sleep, refusal, associated sleep, spi select
    initial begin
        RST_N = 1'h0;
        {INIT_DONE, DTIM_TICK, RX_DATA_PEND, ACTIVITY, assoc_done} = 5'h0;
        cfg = '{SMODE_PIN, SOPT_DEEP, 1'h0, IND_CFG_AWAKE, FLOW_CFG_CTS, SRQ_CFG_SLEEP};
        repeat (8) @(posedge MCLK);
        check({awake_ind, cts_n, attn_n}, 8'h03);
        RST_N <= 1'h1;
        wait_lvl(0, 1'h1, 10);
        check(cts_n, 8'h00);
        @(posedge MCLK);
        assoc_done <= 1'h1;
        hswh_host_inst.set_sleep(1'h1);
        wait_lvl(0, 1'h0, 10);
        check(cts_n, 8'h01);
        pulse(1);
        repeat (6) @(negedge MCLK);
        check({stat.awake, stat.deliver_ok, stat.associated}, 8'h00);
        hswh_host_inst.set_sleep(1'h0);
        wait_lvl(0, 1'h1, 10);
        check(cts_n, 8'h00);
        set_cfg('{SMODE_PIN, SOPT_DEEP, 1'h0, IND_CFG_AWAKE, FLOW_CFG_CTS, 3'h0});
        hswh_host_inst.set_sleep(1'h1);
        repeat (20) @(negedge MCLK);
        check({awake_ind, cts_n}, 8'h02);
        // indicator and cts functions switched off: both stay low asleep
        set_cfg('{SMODE_PIN, SOPT_DEEP, 1'h0, 3'h0, 3'h0, SRQ_CFG_SLEEP});
        wait_lvl(4, 1'h0, 10);
        repeat (2) @(negedge MCLK);
        check({awake_ind, cts_n}, 8'h00);
        // no sleep mode: request is ignored and the device wakes
        set_cfg('{SMODE_NONE, SOPT_DEEP, 1'h0, IND_CFG_AWAKE, FLOW_CFG_CTS, SRQ_CFG_SLEEP});
        wait_lvl(4, 1'h1, 10);
        repeat (10) @(negedge MCLK);
        check(stat.awake, 8'h01);
        set_cfg('{SMODE_PIN, SOPT_ASSOC, 1'h0, IND_CFG_AWAKE, FLOW_CFG_CTS, SRQ_CFG_SLEEP});
        wait_lvl(0, 1'h0, 10);
        repeat (2) @(negedge MCLK);
        check(stat.associated, 8'h01);
        pulse(1);
        repeat (10) @(negedge MCLK);
        check(stat.deliver_ok, 8'h00);
        hswh_host_inst.set_sleep(1'h0);
        wait_lvl(2, 1'h1, 20);
        pulse(2);
        repeat (5) @(negedge MCLK);
        check(stat.tx_release, 8'h00);
        pulse(0);
        wait_lvl(3, 1'h1, 10);
        set_cfg('{SMODE_PIN, SOPT_DEEP, 1'h1, IND_CFG_AWAKE, FLOW_CFG_CTS, SRQ_CFG_SLEEP});
        hswh_host_inst.set_ssel(1'h0);
        @(posedge MCLK);
        INIT_DONE <= 1'h1;
        wait_lvl(1, 1'h0, 10);
        check(status_msg, 8'h01);
        check(awake_ind, 8'h00);
        @(negedge MCLK);
        check(status_msg, 8'h00);
        hswh_host_inst.spi_frame(8);
        hswh_host_inst.set_ssel(1'h1);
        wait_lvl(4, 1'h0, 20);
        hswh_host_inst.set_ssel(1'h0);
        wait_lvl(4, 1'h1, 20);
        test_done();
    end
endmodule
